// File: shared/brs_pkg.sv
// Constants, types and states shared by the buck regulator sequencer
// Behaviour
// - Feedback below reference: upper on, lower off
// - Feedback above reference: upper off, lower on
// - Light-load mode lowers frequency at light load
// - Reference is 0.6V plus code times 4.7mV
// - Enabled only with enable high, supply good
// - After bias settles, ramp reference from zero
// - Output-good held low during reference ramp
// - Output-good rises 45ms after threshold reached
// - Ramp always runs in light-load save mode
// - Peak current over limit turns upper off
// - Upper stays off about 360ns after overcurrent
// - Feedback undervoltage: both off 1.2ms, restart
// - Undervoltage detector ignored during start-up
// - Host sets reference, enable, mode, slew, protections
package brs_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_MHZ = 40; // Reference clock rate
	localparam int OCP_BLANK_NS = 360; // Upper switch lockout after overcurrent
	localparam int OCP_BLANK_CYCLES = (OCP_BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int HICCUP_US = 1200; // Both switches off in hiccup
	localparam int HICCUP_CYCLES = HICCUP_US * CLK_MHZ;
	localparam int PG_DELAY_MS = 45; // Output-good release delay
	localparam int PG_DELAY_CYCLES = PG_DELAY_MS * 1000 * CLK_MHZ;
	localparam int BIAS_SETTLE_US = 10; // Internal bias settling time
	localparam int BIAS_SETTLE_CYCLES = BIAS_SETTLE_US * CLK_MHZ;
	localparam int SLEW_TICK_CYCLES = 40; // One reference step per microsecond

	// ****************************************
	// Reference arithmetic, units of 0.1 mV
	// ****************************************
	localparam int REF_W = 14; // Width of the reference level
	localparam logic [13:0] REF_BASE = 14'h1770; // 0.6 V
	localparam logic [13:0] REF_LSB = 14'h002F; // 4.7 mV per code step
	localparam logic [13:0] REF_RESET = 14'h0000; // Reference starts at 0 V
	localparam logic [6:0] CODE_RESET = 7'h00;
	localparam logic [7:0] SLEW_STEP_0 = 8'h0A; // 1 mV per microsecond
	localparam logic [7:0] SLEW_STEP_1 = 8'h19; // 2.5 mV per microsecond
	localparam logic [7:0] SLEW_STEP_2 = 8'h32; // 5 mV per microsecond
	localparam logic [7:0] SLEW_STEP_3 = 8'h64; // 10 mV per microsecond

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic reg_enable; // Host enable of the regulator
		logic constant_conduction_operation; // 1 forces continuous conduction outside the ramp
		logic [1:0] slew_sel; // Reference slew rate choice
		logic vin_ov_enable; // Input overvoltage protection on
		logic pg_ov_enable; // Output-good also watches overvoltage
		logic [6:0] ref_voltage_code; // Reference code, 0 to 127
	} brs_cfg_t;

	typedef struct packed {
		logic feedback_input; // 1 while feedback is above reference
		logic peak_current_limit; // 1 while peak current over limit
		logic zero_cross; // 1 when inductor current reaches zero
		logic feedback_undervoltage_threshold; // 1 while feedback below UV level
		logic pg_rise_reached; // 1 while feedback over output-good rising level
		logic pg_over; // 1 while feedback over output-good upper level
		logic supply_undervoltage_lockout; // 1 while supply below lockout level
		logic power_input_supply_ov; // 1 while supply is over voltage
	} brs_sense_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_BIAS,
		ST_RAMP,
		ST_RUN,
		ST_HICCUP
	} brs_state_t;

endpackage : brs_pkg

// File: logic/brs_timer.sv
// Loadable down-counter used for every delay of the sequencer
`timescale 1ns/1ps
module brs_timer
	import brs_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic start, // Load and run
	input wire logic abort, // Drop the count
	input wire logic [W-1:0] load, // Cycles to stay busy
	output logic busy
);

	logic [W-1:0] count; // Remaining cycles

	// ****************************************
	// Counter
	// ****************************************
	// Abort wins so a shutdown never leaves a stale delay running
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			count <= '0;
		end else if (abort) begin
			count <= '0;
		end else if (start) begin
			count <= load;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign busy = (count != '0);

endmodule : brs_timer

// File: logic/brs_slew.sv
// Slew-limited reference generator
`timescale 1ns/1ps
module brs_slew
	import brs_pkg::*;
#(
	parameter int TICK = SLEW_TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clear, // Hold level at zero
	input wire logic [REF_W-1:0] target,
	input wire logic [7:0] step,
	output logic [REF_W-1:0] level,
	output logic at_target
);

	logic [15:0] tick_cnt; // Cycles since last step
	logic [REF_W:0] up_sum; // Level plus one step
	logic [REF_W:0] down_dif; // Level minus one step

	assign up_sum = {1'b0, level} + {7'h00, step};
	assign down_dif = {1'b0, level} - {7'h00, step};
	assign at_target = (level == target);

	// ****************************************
	// Step timing
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!resetn || clear) begin
			tick_cnt <= '0;
		end else if (tick_cnt == 16'(TICK - 1)) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
		end
	end

	// ****************************************
	// Level update
	// ****************************************
	// Steps both ways so on-the-fly code changes also slew
	always_ff @(posedge ref_clk) begin
		if (!resetn || clear) begin
			level <= REF_RESET;
		end else if (tick_cnt == 16'(TICK - 1)) begin
			if (level < target) begin
				level <= (up_sum > {1'b0, target}) ? target : up_sum[REF_W-1:0];
			end else if (level > target) begin
				level <= (down_dif[REF_W] || down_dif < {1'b0, target}) ? target
					: down_dif[REF_W-1:0];
			end
		end
	end

endmodule : brs_slew

// File: logic/brs_top.sv
// Switch decisions and start-up sequencing of the step-down converter
`timescale 1ns/1ps
module brs_top
	import brs_pkg::*;
#(
	parameter int HICCUP_CYC = HICCUP_CYCLES, // Hiccup off time
	parameter int PG_DELAY_CYC = PG_DELAY_CYCLES, // Output-good delay
	parameter int BIAS_CYC = BIAS_SETTLE_CYCLES // Bias settle time
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic enable_pin, // Enable input pin
	input wire brs_cfg_t cfg, // Host configuration bits
	input wire brs_sense_t sense, // Comparator results
	output logic upper_switch_on,
	output logic lower_switch_on,
	output logic [REF_W-1:0] ref_level, // Reference to the DAC
	output logic output_good_flag,
	output logic light_load_save_mode, // Save mode in force
	output logic hiccup_active
);

	// ****************************************
	// Declarations
	// ****************************************
	brs_state_t state; // Sequencer state
	brs_state_t next_state;
	logic en_ok; // All enable conditions met
	logic sw_ok; // Switching permitted
	logic save_now; // Save mode selected this cycle
	logic dcm_idle; // Both off after zero crossing
	logic pg_armed; // Output-good delay started
	logic [REF_W-1:0] target; // Programmed reference
	logic [REF_W-1:0] slew_level; // Ramp output
	logic at_target; // Ramp reached target
	logic [7:0] step; // Slew step per tick
	logic bias_busy;
	logic ocp_busy; // Upper lockout after overcurrent
	logic hic_busy;
	logic pg_busy;
	logic bias_start;
	logic hic_start;
	logic ocp_start;
	logic pg_start;
	logic [22:0] pg_age; // Cycles since delay start, checks only

	// ****************************************
	// Enable and mode decode
	// ****************************************
	// Input overvoltage shuts off only when the host has armed it
	assign en_ok = enable_pin && cfg.reg_enable && !sense.supply_undervoltage_lockout
		&& !(cfg.vin_ov_enable && sense.power_input_supply_ov);
	// Switching only during ramp and regulation
	assign sw_ok = en_ok && (state == ST_RAMP || state == ST_RUN);
	// Ramp overrides the programmed mode
	assign save_now = (state == ST_RAMP) || !cfg.constant_conduction_operation;

	// Reference from code, fits 14 bits at code 127
	assign target = REF_BASE + 14'(cfg.ref_voltage_code * REF_LSB);

	// Slew step selection
	always_comb begin
		// Host chosen rate
		case (cfg.slew_sel)
			2'h0: step = SLEW_STEP_0;
			2'h1: step = SLEW_STEP_1;
			2'h2: step = SLEW_STEP_2;
			default: step = SLEW_STEP_3;
		endcase
	end

	// ****************************************
	// Timer starts
	// ****************************************
	assign bias_start = (state == ST_OFF) && en_ok;
	// Undervoltage only counts once regulation is reached
	assign hic_start = (state == ST_RUN) && en_ok && sense.feedback_undervoltage_threshold;
	assign ocp_start = sw_ok && sense.peak_current_limit;
	assign pg_start = (state == ST_RUN) && !pg_armed && sense.pg_rise_reached;

	brs_timer #(.W(16)) u_bias (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(bias_start),
		.abort(!en_ok),
		.load(16'(BIAS_CYC)),
		.busy(bias_busy)
	);

	// Retriggers on every overcurrent cycle
	brs_timer #(.W(8)) u_ocp (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(ocp_start),
		.abort(!sw_ok),
		.load(8'(OCP_BLANK_CYCLES)),
		.busy(ocp_busy)
	);

	brs_timer #(.W(16)) u_hic (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(hic_start),
		.abort(!en_ok),
		// One cycle less: the sequencer spends one more cycle seeing the count end
		.load(16'(HICCUP_CYC - 1)),
		.busy(hic_busy)
	);

	brs_timer #(.W(21)) u_pg (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(pg_start),
		.abort(state != ST_RUN),
		.load(21'(PG_DELAY_CYC)),
		.busy(pg_busy)
	);

	// Reference held at zero until the ramp begins
	brs_slew u_slew (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clear(state != ST_RAMP && state != ST_RUN),
		.target(target),
		.step(step),
		.level(slew_level),
		.at_target(at_target)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			// Wait for enable
			ST_OFF: begin
				if (en_ok) begin
					next_state = ST_BIAS;
				end
			end
			// Bias settling
			ST_BIAS: begin
				if (!bias_busy) begin
					next_state = ST_RAMP;
				end
			end
			// Undervoltage has no path out of here
			ST_RAMP: begin
				if (at_target) begin
					next_state = ST_RUN;
				end
			end
			// Regulation
			ST_RUN: begin
				if (hic_start) begin
					next_state = ST_HICCUP;
				end
			end
			// Off time, then a fresh soft start
			ST_HICCUP: begin
				if (!hic_busy) begin
					next_state = ST_RAMP;
				end
			end
			default: next_state = ST_OFF;
		endcase
		// Losing enable always shuts down
		if (!en_ok) begin
			next_state = ST_OFF;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Light-load idle
	// ****************************************
	// Stopping the lower switch at zero current skips cycles,
	// which is what drops the frequency at light load
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dcm_idle <= 1'b0;
		end else if (!sw_ok || !save_now || !sense.feedback_input) begin
			dcm_idle <= 1'b0;
		end else if (lower_switch_on && sense.zero_cross) begin
			dcm_idle <= 1'b1;
		end
	end

	// ****************************************
	// Switch decisions
	// ****************************************
	// Overcurrent beats the feedback decision
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			upper_switch_on <= 1'b0;
			lower_switch_on <= 1'b0;
		end else if (!sw_ok) begin
			// Off, bias or hiccup
			upper_switch_on <= 1'b0;
			lower_switch_on <= 1'b0;
		end else if (sense.peak_current_limit || ocp_busy) begin
			// Freewheel through the lower switch
			upper_switch_on <= 1'b0;
			lower_switch_on <= !(dcm_idle || (save_now && sense.zero_cross));
		end else if (sense.feedback_input) begin
			// Above reference
			upper_switch_on <= 1'b0;
			lower_switch_on <= !(dcm_idle || (save_now && sense.zero_cross));
		end else begin
			// Below reference
			upper_switch_on <= 1'b1;
			lower_switch_on <= 1'b0;
		end
	end

	// ****************************************
	// Output-good
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pg_armed <= 1'b0;
		end else if (state != ST_RUN) begin
			pg_armed <= 1'b0;
		end else if (pg_start) begin
			pg_armed <= 1'b1;
		end
	end

	// Overvoltage only pulls it down when the host asks
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			output_good_flag <= 1'b0;
		end else begin
			output_good_flag <= (state == ST_RUN) && pg_armed && !pg_busy
				&& sense.pg_rise_reached && !(cfg.pg_ov_enable && sense.pg_over);
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ref_level <= REF_RESET;
			light_load_save_mode <= 1'b0;
			hiccup_active <= 1'b0;
		end else begin
			ref_level <= slew_level;
			light_load_save_mode <= sw_ok && save_now;
			hiccup_active <= (state == ST_HICCUP);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Age of the output-good delay, read only by a check
	always_ff @(posedge ref_clk) begin
		if (!resetn || !pg_armed) begin
			pg_age <= '0;
		end else if (pg_age != '1) begin
			pg_age <= pg_age + 23'h000001;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	below_ref_upper_a: assert property (
		(sw_ok && !sense.feedback_input && !sense.peak_current_limit && !ocp_busy)
		|=> (upper_switch_on && !lower_switch_on))
		else $error("upper switch not on below reference");

	above_ref_upper_a: assert property (
		(sw_ok && sense.feedback_input) |=> !upper_switch_on)
		else $error("upper switch on above reference");

	light_load_idle_a: assert property (
		(sw_ok && save_now && sense.feedback_input && sense.zero_cross) |=> !lower_switch_on)
		else $error("lower switch kept on after zero crossing");

	ref_target_a: assert property (
		(state == ST_RUN && at_target) |=> (ref_level == $past(target)))
		else $error("reference not at programmed code");

	enable_gate_a: assert property (
		!en_ok |=> (state == ST_OFF) ##1 (!upper_switch_on && !lower_switch_on))
		else $error("switching while not enabled");

	ramp_from_zero_a: assert property (
		(state == ST_BIAS) |=> (ref_level == REF_RESET))
		else $error("reference not zero before ramp");

	ramp_pg_low_a: assert property (
		(state == ST_RAMP) |=> !output_good_flag)
		else $error("output-good high during ramp");

	pg_delay_a: assert property (
		$rose(output_good_flag) |-> (pg_age >= 23'(PG_DELAY_CYC)))
		else $error("output-good released early");

	ramp_save_mode_a: assert property (
		(sw_ok && state == ST_RAMP) |=> light_load_save_mode)
		else $error("ramp not in save mode");

	ocp_blank_a: assert property (
		(sw_ok && sense.peak_current_limit) |=> !upper_switch_on [*8])
		else $error("upper switch on during overcurrent lockout");

	hiccup_off_a: assert property (
		(state == ST_RUN && hic_start) |=> ##1 (!upper_switch_on && !lower_switch_on)
		&& !output_good_flag)
		else $error("switches not off in hiccup");

	startup_uv_ignore_a: assert property (
		(state == ST_RAMP && sense.feedback_undervoltage_threshold) |=> (state != ST_HICCUP))
		else $error("hiccup entered during start-up");

	hiccup_restart_a: assert property (
		(state == ST_HICCUP && !hic_busy && en_ok) |=> (state == ST_RAMP) ##1 !output_good_flag)
		else $error("hiccup did not restart soft start");

	ramp_done_c: cover property ((state == ST_RAMP) ##1 (state == ST_RUN));
	hiccup_c: cover property ((state == ST_RUN) ##1 (state == ST_HICCUP));
	ocp_event_c: cover property (sw_ok && sense.peak_current_limit);
	pg_rise_c: cover property ($rose(output_good_flag));

endmodule : brs_top

// File: verif/brs_stage_model.sv
// Behavioural power stage and comparators facing the sequencer
`timescale 1ns/1ps
module brs_stage_model
	import brs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic upper_switch_on,
	input wire logic lower_switch_on,
	input wire logic [REF_W-1:0] ref_level,
	input wire logic [1:0] fb_force, // 2 forces below, 3 above, else model
	input wire logic oc_cmd, // Peak current over limit
	input wire logic light_cmd, // Light load, current reaches zero
	input wire logic short_cmd, // Crowbar on the output
	input wire logic over_cmd, // Output above upper good level
	input wire logic lockout_cmd, // Supply below lockout
	input wire logic supply_ov_cmd, // Supply over voltage
	output brs_sense_t sense
);
	// ****************************************
	// Output node
	// ****************************************
	int vout = 0; // Output in 0.1 mV units
	// Crude integrator; the load bleeds charge slowly with both switches off
	always @(posedge ref_clk) begin
		if (short_cmd)
			vout <= 0;
		else if (upper_switch_on)
			vout <= vout + 40;
		else if (lower_switch_on)
			vout <= (vout > 40) ? vout - 40 : 0;
		else
			vout <= (vout > 2) ? vout - 2 : 0;
	end
	// Comparators against the live reference, thresholds at 80 and 90 percent
	always_comb begin
		sense.feedback_input = fb_force[1] ? fb_force[0] : (vout > int'(ref_level));
		sense.peak_current_limit = oc_cmd;
		sense.zero_cross = light_cmd;
		sense.feedback_undervoltage_threshold = (vout * 10 < int'(ref_level) * 8);
		sense.pg_rise_reached = (vout * 10 >= int'(ref_level) * 9);
		sense.pg_over = over_cmd;
		sense.supply_undervoltage_lockout = lockout_cmd;
		sense.power_input_supply_ov = supply_ov_cmd;
	end
endmodule : brs_stage_model

// File: verif/brs_top_tb_top.sv
// Self-checking bench for the buck regulator sequencer
`timescale 1ns/1ps
module brs_top_tb_top;
	import brs_pkg::*;
	// ****************************************
	// Short counts and wiring
	// ****************************************
	localparam int HC = 50; // Hiccup off time, shortened
	localparam int PGD = 100; // Output-good delay, shortened
	localparam int BC = 4; // Bias settle, shortened
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic enable_pin = 1'b0;
	brs_cfg_t cfg = '0;
	brs_sense_t sense;
	logic [1:0] fb_force = 2'h0;
	logic oc_cmd = 1'b0;
	logic light_cmd = 1'b0;
	logic short_cmd = 1'b0;
	logic over_cmd = 1'b0;
	logic lockout_cmd = 1'b0;
	logic supply_ov_cmd = 1'b0;
	logic upper_switch_on, lower_switch_on, output_good_flag, light_load_save_mode;
	logic hiccup_active;
	logic [REF_W-1:0] ref_level;
	logic [REF_W-1:0] a; // Earlier reference sample
	int err_total = 0;
	int n_compared = 0;
	int n; // Cycle counter
	int bad; // Cycles seen in a wrong state
	int steps [4] = '{10, 25, 50, 100}; // Step per tick for each slew choice
	brs_top #(.HICCUP_CYC(HC), .PG_DELAY_CYC(PGD), .BIAS_CYC(BC)) brs_top_i (
		.ref_clk(ref_clk), .resetn(resetn), .enable_pin(enable_pin), .cfg(cfg),
		.sense(sense), .upper_switch_on(upper_switch_on), .lower_switch_on(lower_switch_on),
		.ref_level(ref_level), .output_good_flag(output_good_flag),
		.light_load_save_mode(light_load_save_mode), .hiccup_active(hiccup_active));
	brs_stage_model brs_stage_model_i (
		.ref_clk(ref_clk), .upper_switch_on(upper_switch_on),
		.lower_switch_on(lower_switch_on), .ref_level(ref_level), .fb_force(fb_force),
		.oc_cmd(oc_cmd), .light_cmd(light_cmd), .short_cmd(short_cmd),
		.over_cmd(over_cmd), .lockout_cmd(lockout_cmd), .supply_ov_cmd(supply_ov_cmd),
		.sense(sense));
	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Reference in 0.1 mV units for a code
	function automatic logic [REF_W-1:0] ref_of(input logic [6:0] code);
		return 14'(6000 + int'(code) * 47);
	endfunction : ref_of
	// Step past the next rising edge; inputs move 1 ns after it
	task automatic tick(input int cyc);
		repeat (cyc) begin
			@(posedge ref_clk);
			#1;
		end
	endtask : tick
	task automatic check(input bit ok, input string msg);
		n_compared++;
		if (!ok) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// Ramp to target watching flag and mode, then time the good delay
	task automatic startup();
		bad = 0;
		n = 0;
		while (n < 8000 && ref_level !== ref_of(cfg.ref_voltage_code)) begin
			if (output_good_flag !== 1'b0 || (ref_level > 14'h0064 && light_load_save_mode !== 1'b1))
				bad++;
			tick(1);
			n++;
		end
		check(ref_level === ref_of(cfg.ref_voltage_code), "ramp end level");
		check(bad == 0, "good flag or save mode during ramp");
		n = 0;
		while (n < PGD + 20 && output_good_flag !== 1'b1) begin
			tick(1);
			n++;
		end
		check(n >= PGD - 2 && n <= PGD + 4, "output-good delay");
		tick(4);
		check(light_load_save_mode === 1'b0, "continuous mode kept after ramp");
	endtask : startup
	// Watchdog, far beyond three start-ups
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_total++;
		$display("CHECK FAILED at %0t: timeout", $time);
		report_and_stop();
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		tick(6);
		resetn = 1'b1;
		tick(1);
		check({upper_switch_on, lower_switch_on, output_good_flag} === 3'h0, "reset");
		cfg.slew_sel = 2'h3;
		cfg.constant_conduction_operation = 1'b1;
		cfg.vin_ov_enable = 1'b1;
		cfg.ref_voltage_code = 7'h7F;
		// Each case lacks one enable condition
		for (int k = 0; k < 4; k++) begin
			enable_pin = (k != 0);
			lockout_cmd = (k == 1);
			supply_ov_cmd = (k == 2);
			cfg.reg_enable = (k != 3);
			tick(30);
			check({upper_switch_on, lower_switch_on} === 2'h0 && ref_level === 14'h0, "off");
		end
		cfg.reg_enable = 1'b1;
		tick(BC + 3);
		check(ref_level < 14'h00C8, "ramp starts near zero");
		startup();
		fb_force = 2'h2;
		tick(3);
		check(upper_switch_on === 1'b1 && lower_switch_on === 1'b0, "below ref");
		fb_force = 2'h3;
		tick(3);
		check(upper_switch_on === 1'b0 && lower_switch_on === 1'b1, "above ref");
		// One overcurrent cycle, then the upper lockout
		fb_force = 2'h2;
		tick(3);
		oc_cmd = 1'b1;
		tick(1);
		oc_cmd = 1'b0;
		bad = 0;
		repeat (15) begin
			tick(1);
			if (upper_switch_on !== 1'b0)
				bad++;
		end
		check(bad == 0, "upper held off after overcurrent");
		tick(2);
		check(upper_switch_on === 1'b1, "upper back after lockout");
		// Light load skips the lower switch only in save mode
		cfg.constant_conduction_operation = 1'b0;
		light_cmd = 1'b1;
		fb_force = 2'h3;
		tick(4);
		check(lower_switch_on === 1'b0 && light_load_save_mode === 1'b1, "skip");
		cfg.constant_conduction_operation = 1'b1;
		tick(4);
		check(lower_switch_on === 1'b1 && light_load_save_mode === 1'b0, "continuous mode");
		light_cmd = 1'b0;
		fb_force = 2'h0;
		tick(20);
		// Overvoltage watch on the good flag is selectable
		over_cmd = 1'b1;
		tick(3);
		check(output_good_flag === 1'b1, "over ignored");
		cfg.pg_ov_enable = 1'b1;
		tick(3);
		check(output_good_flag === 1'b0, "over drops flag");
		over_cmd = 1'b0;
		// On-the-fly code change moves one step per tick at each slew choice
		for (int k = 0; k < 4; k++) begin
			cfg.slew_sel = 2'(k);
			cfg.ref_voltage_code = 7'h00;
			tick(80);
			a = ref_level;
			tick(40);
			check(14'(a - ref_level) === 14'(steps[k]), "slew step");
			cfg.ref_voltage_code = 7'h7F;
			n = 0;
			while (n < 2000 && ref_level !== ref_of(7'h7F)) begin
				tick(1);
				n++;
			end
		end
		// Supply overvoltage only counts when enabled
		cfg.vin_ov_enable = 1'b0;
		supply_ov_cmd = 1'b1;
		tick(5);
		check((upper_switch_on | lower_switch_on) === 1'b1, "ov ignored");
		cfg.vin_ov_enable = 1'b1;
		tick(3);
		check({upper_switch_on, lower_switch_on} === 2'h0, "ov shutdown");
		supply_ov_cmd = 1'b0;
		tick(BC + 200);
		short_cmd = 1'b1;
		tick(100);
		check(hiccup_active === 1'b0, "no hiccup in start-up");
		short_cmd = 1'b0;
		startup();
		// Crowbar in run: hiccup, then a full new start-up
		short_cmd = 1'b1;
		tick(3);
		check(hiccup_active === 1'b1 && output_good_flag === 1'b0, "hiccup");
		short_cmd = 1'b0;
		n = 0;
		bad = 0;
		while (n < HC + 20 && hiccup_active === 1'b1) begin
			if ({upper_switch_on, lower_switch_on} !== 2'h0)
				bad++;
			tick(1);
			n++;
		end
		check(bad == 0 && n >= HC - 2 && n <= HC, "hiccup off time");
		tick(2);
		check(ref_level < 14'h00C8, "ref restarts from zero");
		startup();
		report_and_stop();
	end
endmodule : brs_top_tb_top
